// [src/anr_consts.svh]
`ifndef ANR_CONSTS_SVH
`define ANR_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ANR_OFF_EXPANSION 5'h06
`define ANR_OFF_NP_TX 5'h07
`define ANR_OFF_NP_RX 5'h08
`define ANR_OFF_IRQ_STAT 5'h1c
`define ANR_OFF_IRQ_MASK 5'h1d

// ----------------------------------------
// Expansion register bit positions
// ----------------------------------------
`define ANR_EXP_PD_FAULT 4
`define ANR_EXP_LP_NP_ABLE 3
`define ANR_EXP_LOCAL_NP_ABLE 2
`define ANR_EXP_PAGE_RX 1
`define ANR_EXP_LP_AN_ABLE 0

// ----------------------------------------
// Interrupt status bit positions
// ----------------------------------------
`define ANR_IRQ_PD_FAULT 0
`define ANR_IRQ_PAGE_RX 1
`define ANR_IRQ_NUM 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ANR_LOCAL_NP_ABLE 1'b1
`define ANR_NP_TX_CODE_RST 11'h001
`define ANR_NP_RX_RST 16'h0000
`define ANR_IRQ_RST 2'h0

`endif

// [src/anr_pkg.sv]
`default_nettype none
package anr_pkg;

  // Management access: one strobe at a time, read data one cycle later
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } anr_bus_req_t;

  // Layout of a next-page code word
  typedef struct packed {
    logic next_page;
    logic rsvd;
    logic message_page_flag;
    logic comply_acknowledge;
    logic toggle;
    logic [10:0] message_or_unformatted_code;
  } anr_np_word_t;

  // Status from the auto-negotiation arbitration logic
  typedef struct packed {
    logic an_enable;
    logic pd_fault;
    logic page_rx;
    logic page_tx_done;
    logic partner_np_able;
    logic partner_autoneg_able;
    anr_np_word_t rx_word;
  } anr_an_in_t;

  typedef struct packed {
    logic pd_fault;
    logic page_rx;
    anr_np_word_t tx;
    anr_np_word_t rx;
    logic [15:0] rd_data;
  } anr_regs_state_t;

  typedef struct packed {
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
  } anr_irq_state_t;

endpackage

`default_nettype wire

// [src/anr_irq.sv]
`timescale 1ns/10ps
`default_nettype none
`include "anr_consts.svh"

module anr_irq (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] event_in,
  input wire logic wr_stat,
  input wire logic wr_mask,
  input wire logic [1:0] wdata,
  output logic [1:0] stat,
  output logic [1:0] mask,
  output logic irq
);
  import anr_pkg::*;

  anr_irq_state_t s_q;
  anr_irq_state_t s_d;
  logic [1:0] stat_nx;

  // ----------------------------------------
  // Sticky bits, write one to clear
  // ----------------------------------------
  // A new event in the clearing cycle keeps its bit set
  genvar i;
  generate
    for (i = 0; i < `ANR_IRQ_NUM; i++)
    begin : g_stat
      assign stat_nx[i] = event_in[i] | (s_q.stat[i] & ~(wr_stat & wdata[i]));
    end
  endgenerate

  always_comb
  begin
    s_d = s_q;
    s_d.stat = stat_nx;
    if (wr_mask)
    begin
      s_d.mask = wdata;
    end
    s_d.irq = |(s_d.stat & s_d.mask);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign stat = s_q.stat;
  assign mask = s_q.mask;
  assign irq = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_irq_level: assert property (irq == |(stat & mask))
    else $error("irq output disagrees with masked status");
  a_stat_sticky: assert property (event_in[0] |=> stat[0])
    else $error("event did not set its status bit");
  a_stat_w1c: assert property (wr_stat && wdata[1] && !event_in[1] |=> !stat[1])
    else $error("write one did not clear status bit");
endmodule

`default_nettype wire

// [src/anr_regs.sv]
// How it works
// [RULE1] Parallel detection fault sets expansion bit 4; reading the register clears it.
// [RULE2] Expansion bit 3 shows whether the partner is next-page capable.
// [RULE3] Expansion bit 2 shows local next-page capability, reading one by default.
// [RULE4] A new page from the partner sets expansion bit 1; a read clears it.
// [RULE5] With auto-negotiation on, expansion bit 0 shows partner auto-negotiation ability.
// [RULE6] Writable transmit next-page word; code field resets to one, rest zero.
// [RULE7] Every page received is captured into a read-only word resetting to zero.
// [RULE8] Bit 15 of either word is one while more pages follow.
// [RULE9] Bit 13 marks message page; writable on transmit, read-only on receive.
// [RULE10] Bits 10 to 0 are message code or unformatted code per bit 13.
// [RULE11] Bit 12 says whether the sender can comply with the message.
// [RULE12] Bit 11 is the inverted previous toggle, driven by hardware only.
// [RULE13] Reading a clear-on-read bit returns the old value, clearing afterwards.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "anr_consts.svh"

module anr_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire anr_pkg::anr_bus_req_t bus,
  input wire anr_pkg::anr_an_in_t an,
  output logic [15:0] rd_data,
  output anr_pkg::anr_np_word_t np_tx_word,
  output logic irq
);
  import anr_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  anr_regs_state_t s_q;
  anr_regs_state_t s_d;
  logic rd_exp;
  logic wr_tx;
  logic wr_istat;
  logic wr_imask;
  logic [1:0] istat;
  logic [1:0] imask;
  logic [15:0] exp_val;
  logic lp_an_view;

  assign rd_exp = bus.rd && hit(bus.addr, `ANR_OFF_EXPANSION);
  assign wr_tx = bus.wr && hit(bus.addr, `ANR_OFF_NP_TX);
  assign wr_istat = bus.wr && hit(bus.addr, `ANR_OFF_IRQ_STAT);
  assign wr_imask = bus.wr && hit(bus.addr, `ANR_OFF_IRQ_MASK);

  // Partner ability is only meaningful while negotiation runs
  assign lp_an_view = an.an_enable & an.partner_autoneg_able; // [RULE5]

  // ----------------------------------------
  // Expansion register view
  // ----------------------------------------
  always_comb
  begin
    exp_val = 16'h0000;
    exp_val[`ANR_EXP_PD_FAULT] = s_q.pd_fault; // [RULE1]
    exp_val[`ANR_EXP_LP_NP_ABLE] = an.partner_np_able; // [RULE2]
    exp_val[`ANR_EXP_LOCAL_NP_ABLE] = `ANR_LOCAL_NP_ABLE; // [RULE3]
    exp_val[`ANR_EXP_PAGE_RX] = s_q.page_rx; // [RULE4]
    exp_val[`ANR_EXP_LP_AN_ABLE] = lp_an_view; // [RULE5]
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Read returns the held value, the clear lands on the same edge;
    // an event in that cycle wins so it is never lost
    if (rd_exp)
    begin
      s_d.pd_fault = 1'b0; // [RULE1] [RULE13]
      s_d.page_rx = 1'b0; // [RULE4] [RULE13]
    end
    if (an.pd_fault)
    begin
      s_d.pd_fault = 1'b1; // [RULE1]
    end
    if (an.page_rx)
    begin
      s_d.page_rx = 1'b1; // [RULE4]
      s_d.rx = an.rx_word; // [RULE7] [RULE8] [RULE9] [RULE10] [RULE11]
      s_d.rx.rsvd = 1'b0;
    end
    if (wr_tx)
    begin
      s_d.tx.next_page = bus.wdata[15]; // [RULE8]
      s_d.tx.message_page_flag = bus.wdata[13]; // [RULE9]
      s_d.tx.comply_acknowledge = bus.wdata[12]; // [RULE11]
      s_d.tx.message_or_unformatted_code = bus.wdata[10:0]; // [RULE6] [RULE10]
    end
    // Toggle alternates per exchanged word; software writes cannot touch it
    if (an.page_tx_done)
    begin
      s_d.tx.toggle = ~s_q.tx.toggle; // [RULE12]
    end
    // Registered answer: one cycle of latency, but the flags and the clear share a single edge
    s_d.rd_data = 16'h0000;
    if (bus.rd)
    begin
      if (hit(bus.addr, `ANR_OFF_EXPANSION))
      begin
        s_d.rd_data = exp_val; // [RULE13]
      end
      else if (hit(bus.addr, `ANR_OFF_NP_TX))
      begin
        s_d.rd_data = s_q.tx;
      end
      else if (hit(bus.addr, `ANR_OFF_NP_RX))
      begin
        s_d.rd_data = s_q.rx;
      end
      else if (hit(bus.addr, `ANR_OFF_IRQ_STAT))
      begin
        s_d.rd_data = {14'h0000, istat};
      end
      else if (hit(bus.addr, `ANR_OFF_IRQ_MASK))
      begin
        s_d.rd_data = {14'h0000, imask};
      end
      else
      begin
        s_d.rd_data = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_q.pd_fault <= 1'b0;
      s_q.page_rx <= 1'b0;
      // Toggle starts cleared, so the first exchanged word carries a zero there
      s_q.tx <= {5'h00, `ANR_NP_TX_CODE_RST}; // [RULE6]
      s_q.rx <= `ANR_NP_RX_RST; // [RULE7]
      s_q.rd_data <= 16'h0000;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  anr_irq u_irq (
    .clk(clk),
    .rst_b(rst_b),
    .event_in({an.page_rx, an.pd_fault}),
    .wr_stat(wr_istat),
    .wr_mask(wr_imask),
    .wdata(bus.wdata[1:0]),
    .stat(istat),
    .mask(imask),
    .irq(irq)
  );

  assign rd_data = s_q.rd_data;
  assign np_tx_word = s_q.tx;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_exp_read;
    rd_exp && !an.pd_fault && !an.page_rx;
  endsequence

  sequence s_old_flags_returned;
    rd_data[`ANR_EXP_PD_FAULT] == $past(s_q.pd_fault) && rd_data[`ANR_EXP_PAGE_RX] == $past(s_q.page_rx);
  endsequence

  a_pdf_set: assert property (an.pd_fault |=> s_q.pd_fault) // [RULE1]
    else $error("fault event did not set the fault flag");
  a_prx_set: assert property (an.page_rx |=> s_q.page_rx) // [RULE4]
    else $error("page event did not set the page flag");
  a_read_clears: assert property (s_exp_read |=> s_old_flags_returned ##0 (!s_q.pd_fault && !s_q.page_rx)) // [RULE13]
    else $error("expansion read lost old flags or did not clear");
  a_exp_status: assert property (rd_exp |=> rd_data[3] == $past(an.partner_np_able) && rd_data[2] // [RULE2]
    && rd_data[0] == $past(an.an_enable && an.partner_autoneg_able) && rd_data[15:5] == 11'h000)
    else $error("expansion status bits wrong");
  a_tx_write: assert property (wr_tx |=> np_tx_word.next_page == $past(bus.wdata[15]) // [RULE6]
    && np_tx_word.message_page_flag == $past(bus.wdata[13]) && np_tx_word.comply_acknowledge == $past(bus.wdata[12])
    && np_tx_word.message_or_unformatted_code == $past(bus.wdata[10:0]) && !np_tx_word.rsvd)
    else $error("transmit word write not stored");
  a_toggle_flip: assert property (an.page_tx_done |=> np_tx_word.toggle != $past(np_tx_word.toggle)) // [RULE12]
    else $error("toggle did not invert after exchange");
  a_toggle_hold: assert property (!an.page_tx_done |=> $stable(np_tx_word.toggle)) // [RULE12]
    else $error("toggle moved without an exchange");
  a_rx_capture: assert property (an.page_rx |=> s_q.rx == ($past(an.rx_word) & 16'hbfff)) // [RULE7]
    else $error("received page not captured");
  a_rd_only_once: assert property (!bus.rd |=> rd_data == 16'h0000)
    else $error("read data outside the answer cycle");

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  // The first edge after release still shows the reset state; a request lands one edge later
  sequence s_reset_released;
    $rose(rst_b);
  endsequence

  sequence s_reset_state;
    np_tx_word == {5'h00, `ANR_NP_TX_CODE_RST} && s_q.rx == `ANR_NP_RX_RST && rd_data == 16'h0000
      && !s_q.pd_fault && !s_q.page_rx && !irq;
  endsequence

  a_reset_values: assert property (s_reset_released |-> s_reset_state) // [RULE6] [RULE7]
    else $error("state after reset release is not the reset state");
  a_tx_rsvd_zero: assert property (!np_tx_word.rsvd) // [RULE6]
    else $error("reserved bit of transmit word is set");
  a_rx_rsvd_zero: assert property (!s_q.rx.rsvd) // [RULE7]
    else $error("reserved bit of received word is set");

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  sequence s_flags_quiet;
    !rd_exp && !an.pd_fault && !an.page_rx;
  endsequence

  sequence s_flags_unchanged;
    $stable(s_q.pd_fault) && $stable(s_q.page_rx);
  endsequence

  a_flags_hold: assert property (s_flags_quiet |=> s_flags_unchanged) // [RULE1] [RULE4]
    else $error("status flag moved without event or read");
  a_set_wins: assert property (rd_exp |=> s_q.pd_fault == $past(an.pd_fault) // [RULE13]
    && s_q.page_rx == $past(an.page_rx))
    else $error("read clear lost an event of the same cycle");
  a_exp_fault_bit: assert property (rd_exp |=> rd_data[`ANR_EXP_PD_FAULT] == $past(s_q.pd_fault)) // [RULE1]
    else $error("fault flag not returned by the read");
  a_exp_page_bit: assert property (rd_exp |=> rd_data[`ANR_EXP_PAGE_RX] == $past(s_q.page_rx)) // [RULE4]
    else $error("page flag not returned by the read");
  a_exp_partner_np: assert property (rd_exp |=> rd_data[`ANR_EXP_LP_NP_ABLE] == $past(an.partner_np_able)) // [RULE2]
    else $error("partner next-page ability read wrong");
  a_exp_local_np: assert property (rd_exp |=> rd_data[`ANR_EXP_LOCAL_NP_ABLE]) // [RULE3]
    else $error("local next-page ability not reported");
  a_exp_an_off: assert property (rd_exp && !an.an_enable |=> !rd_data[`ANR_EXP_LP_AN_ABLE]) // [RULE5]
    else $error("partner ability shown while negotiation is off");
  a_exp_an_on: assert property (rd_exp && an.an_enable // [RULE5]
    |=> rd_data[`ANR_EXP_LP_AN_ABLE] == $past(an.partner_autoneg_able))
    else $error("partner ability not shown while negotiation is on");

  // ----------------------------------------
  // Transmit and received words
  // ----------------------------------------
  a_tx_hold: assert property (!wr_tx |=> $stable({np_tx_word.next_page, np_tx_word.message_page_flag, // [RULE6]
    np_tx_word.comply_acknowledge, np_tx_word.message_or_unformatted_code}))
    else $error("transmit word changed without a write");
  a_toggle_no_write: assert property (wr_tx && !an.page_tx_done // [RULE12]
    |=> np_tx_word.toggle == $past(np_tx_word.toggle))
    else $error("software write moved the toggle bit");
  a_rx_hold: assert property (!an.page_rx |=> $stable(s_q.rx)) // [RULE7]
    else $error("received word changed without a page");
  a_rx_fields: assert property (an.page_rx // [RULE8] [RULE9] [RULE10] [RULE11]
    |=> s_q.rx.next_page == $past(an.rx_word.next_page)
    && s_q.rx.message_page_flag == $past(an.rx_word.message_page_flag)
    && s_q.rx.comply_acknowledge == $past(an.rx_word.comply_acknowledge)
    && s_q.rx.message_or_unformatted_code == $past(an.rx_word.message_or_unformatted_code))
    else $error("received page fields not captured");

  // ----------------------------------------
  // Read answers
  // ----------------------------------------
  sequence s_rd_unmapped;
    bus.rd && bus.addr != `ANR_OFF_EXPANSION && bus.addr != `ANR_OFF_NP_TX && bus.addr != `ANR_OFF_NP_RX
      && bus.addr != `ANR_OFF_IRQ_STAT && bus.addr != `ANR_OFF_IRQ_MASK;
  endsequence

  a_rd_tx_word: assert property (bus.rd && bus.addr == `ANR_OFF_NP_TX |=> rd_data == $past(s_q.tx)) // [RULE12]
    else $error("transmit word read back wrong");
  a_rd_rx_word: assert property (bus.rd && bus.addr == `ANR_OFF_NP_RX |=> rd_data == $past(s_q.rx)) // [RULE7]
    else $error("received word read back wrong");
  a_rd_istat: assert property (bus.rd && bus.addr == `ANR_OFF_IRQ_STAT |=> rd_data == {14'h0, $past(istat)})
    else $error("interrupt status read back wrong");
  a_rd_imask: assert property (bus.rd && bus.addr == `ANR_OFF_IRQ_MASK |=> rd_data == {14'h0, $past(imask)})
    else $error("interrupt mask read back wrong");
  a_rd_unmapped: assert property (s_rd_unmapped |=> rd_data == 16'h0000)
    else $error("unmapped read returned data");

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // A mask write in the same cycle is left out: the new mask decides then
  a_stat_on_fault: assert property (an.pd_fault |=> istat[`ANR_IRQ_PD_FAULT])
    else $error("fault event did not set its interrupt status bit");
  a_stat_on_page: assert property (an.page_rx |=> istat[`ANR_IRQ_PAGE_RX])
    else $error("page event did not set its interrupt status bit");
  a_stat_clear: assert property (wr_istat && bus.wdata[`ANR_IRQ_PD_FAULT] && !an.pd_fault
    |=> !istat[`ANR_IRQ_PD_FAULT])
    else $error("write one did not clear the fault status bit");
  a_mask_write: assert property (wr_imask |=> imask == $past(bus.wdata[1:0]))
    else $error("interrupt mask write not stored");
  a_irq_on_fault: assert property (an.pd_fault && imask[`ANR_IRQ_PD_FAULT] && !wr_imask |=> irq)
    else $error("unmasked fault event did not raise the interrupt");
  a_irq_on_page: assert property (an.page_rx && imask[`ANR_IRQ_PAGE_RX] && !wr_imask |=> irq)
    else $error("unmasked page event did not raise the interrupt");
endmodule

`default_nettype wire

// [bench/anr_partner_model.sv]
`timescale 1ns/10ps
`default_nettype none
module anr_partner_model (
  input wire logic clk,
  output var anr_pkg::anr_an_in_t an
);
  import anr_pkg::*;
  initial an = '0;
  // Levels {an_enable, partner_np_able, partner_autoneg_able}
  task automatic lv(input logic [2:0] l);
    @(posedge clk);
    an.an_enable <= l[2];
    an.partner_np_able <= l[1];
    an.partner_autoneg_able <= l[0];
  endtask
  // Pulses {pd_fault, page_rx, page_tx_done}, word sent as given
  task automatic ev(input logic [2:0] e, input anr_np_word_t w);
    @(posedge clk);
    an.pd_fault <= e[2];
    an.page_rx <= e[1];
    an.page_tx_done <= e[0];
    an.rx_word <= w;
    @(posedge clk);
    an.pd_fault <= 1'b0;
    an.page_rx <= 1'b0;
    an.page_tx_done <= 1'b0;
    // Stale word inverted so a late capture shows
    an.rx_word <= ~w;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import anr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  anr_bus_req_t bus = '0;
  anr_an_in_t an;
  logic [15:0] rd_data;
  anr_np_word_t np_tx_word;
  logic irq;
  logic rd_seen = 1'b0;
  logic [15:0] expq[$];
  logic [15:0] w;
  logic [15:0] x;
  logic tog = 1'b0;
  int fails = 0;
  int compares = 0;
  always #2 clk = ~clk;
  anr_regs uut (.clk(clk), .rst_b(rst_b), .bus(bus), .an(an), .rd_data(rd_data), .np_tx_word(np_tx_word),
    .irq(irq));
  anr_partner_model p (.clk(clk), .an(an));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.wdata <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    expq.push_back(e);
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  // Let the edge's updates land before a level output is looked at
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Read answers, one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rd_seen)
      chk(rd_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
    rd_seen <= bus.rd;
  end
  initial
  begin
    void'($urandom(80777));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk(np_tx_word, 16'h0001);
    rd(5'h06, 16'h0004);
    rd(5'h07, 16'h0001);
    rd(5'h08, 16'h0000);
    rd(5'h1f, 16'h0000);
    p.lv(3'b011);
    rd(5'h06, 16'h000c);
    p.lv(3'b111);
    wr(5'h06, 16'hffff);
    rd(5'h06, 16'h000d);
    wr(5'h1d, 16'h0003);
    p.ev(3'b100, '0);
    settle();
    chk({15'h0000, irq}, 16'h0001);
    rd(5'h06, 16'h001d);
    rd(5'h06, 16'h000d);
    rd(5'h1c, 16'h0001);
    wr(5'h1c, 16'h0001);
    rd(5'h1c, 16'h0000);
    settle();
    chk({15'h0000, irq}, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      w = 16'($urandom);
      p.ev(3'b011, w);
      tog = ~tog;
      rd(5'h08, {w[15], 1'b0, w[13:0]});
      rd(5'h06, 16'h000f);
      rd(5'h06, 16'h000d);
      rd(5'h07, {4'h0, tog, 11'h001});
    end
    settle();
    chk({15'h0000, irq}, 16'h0001);
    w = 16'($urandom);
    x = {w[15], 1'b0, w[13:12], tog, w[10:0]};
    wr(5'h07, w);
    settle();
    chk(np_tx_word, x);
    rd(5'h07, x);
    rd(5'h1c, 16'h0002);
    wr(5'h1d, 16'h0001);
    settle();
    settle();
    chk({15'h0000, irq}, 16'h0000);
    settle();
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
